// >>> design/bstp_pkg.sv
// package of constants and types for the boundary-scan test port
package bstp_pkg;

    // ****************************************************************
    // register lengths and variants
    // ****************************************************************
    localparam int BSTP_IR_LEN = 3;
    localparam int BSTP_BSR_LEN_V0 = 273;
    localparam int BSTP_BSR_LEN_V1 = 417;
    localparam int BSTP_BSR_LEN_V2 = 465;
    localparam int BSTP_BSR_LEN_V3 = 645;
    localparam int BSTP_BSR_LEN_DEFAULT = BSTP_BSR_LEN_V0;

    // ****************************************************************
    // cell layout: three cells per pin, input cell nearest to tdo
    // ****************************************************************
    localparam int BSTP_CELLS_PER_PIN = 3;
    localparam int BSTP_CELL_IN = 0;
    localparam int BSTP_CELL_OUT = 1;
    localparam int BSTP_CELL_OE = 2;

    // ****************************************************************
    // instruction codes and reset values
    // ****************************************************************
    localparam logic [BSTP_IR_LEN-1:0] BSTP_IR_EXTEST = 3'h0;
    localparam logic [BSTP_IR_LEN-1:0] BSTP_IR_SAMPLE = 3'h5;
    localparam logic [BSTP_IR_LEN-1:0] BSTP_IR_BYPASS = 3'h7;
    localparam logic [BSTP_IR_LEN-1:0] BSTP_IR_CAPTURE = 3'h1;
    localparam logic BSTP_BYPASS_CAPTURE = 1'h0;
    localparam logic BSTP_PULLUP_LEVEL = 1'h1;

    // ****************************************************************
    // buffering and tap timing
    // ****************************************************************
    localparam int BSTP_FIFO_DEPTH = 8;
    localparam int BSTP_TMS_RESET_TCKS = 5;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [3:0] {
        TLR, RTI,
        SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } bstp_tap_state_t;

    typedef enum logic [1:0] {
        INS_BYPASS, INS_SAMPLE, INS_EXTEST
    } bstp_instr_t;

    // strobes decoded from the tap state
    typedef struct packed {
        logic reset;
        logic capture_ir;
        logic shift_ir;
        logic update_ir;
        logic capture_dr;
        logic shift_dr;
        logic update_dr;
    } bstp_tap_t;

endpackage : bstp_pkg

// >>> design/bstp_fifo.sv
// single-clock fifo with a registered read stage
`timescale 1ns/1ps
`default_nettype none

module bstp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    // ****************************************************************
    // parameter check
    // ****************************************************************
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
        $error("bstp_fifo: depth must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic [WIDTH-1:0] out_data_reg;
    logic out_valid_reg;
    logic push;
    logic load;

    // handshake terms
    assign in_ready = (count_reg != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign push = in_valid & in_ready;
    assign load = (count_reg != '0) & (~out_valid_reg | out_ready);
    assign out_valid = out_valid_reg;
    assign out_data = out_data_reg;

    // storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + AW'(1);
            end
            if (load) begin
                rd_ptr_reg <= rd_ptr_reg + AW'(1);
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(load);
        end
    end

    // registered head word
    always_ff @(posedge clk) begin
        if (rst) begin
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end else if (load) begin
            out_valid_reg <= 1'b1;
            out_data_reg <= mem_reg[rd_ptr_reg];
        end else if (out_ready) begin
            out_valid_reg <= 1'b0;
        end
    end

endmodule : bstp_fifo

`default_nettype wire

// >>> design/bstp_top.sv
// boundary-scan test port: tap controller, scan registers, pin control
`timescale 1ns/1ps
`default_nettype none

module bstp_top
    import bstp_pkg::*;
#(
    parameter int BSR_LEN = BSTP_BSR_LEN_DEFAULT,
    parameter int FIFO_DEPTH = BSTP_FIFO_DEPTH,
    localparam int PINS = BSR_LEN / BSTP_CELLS_PER_PIN
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms_pin,
    input wire logic tms_drive,
    input wire logic tdi_pin,
    input wire logic tdi_drive,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [PINS-1:0] pin_in,
    input wire logic [PINS-1:0] core_out,
    input wire logic [PINS-1:0] core_oe,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe
);

    // ****************************************************************
    // parameter check
    // ****************************************************************
    if (BSR_LEN != BSTP_BSR_LEN_V0 && BSR_LEN != BSTP_BSR_LEN_V1 &&
        BSR_LEN != BSTP_BSR_LEN_V2 && BSR_LEN != BSTP_BSR_LEN_V3) begin
        $error("bstp_top: unsupported scan register length");
    end

    // ****************************************************************
    // functions
    // ****************************************************************
    // tap state transition on one tck edge
    function automatic bstp_tap_state_t tap_next(bstp_tap_state_t s,
                                                 logic m);
        bstp_tap_state_t n;
        n = s;
        unique case (s)
            TLR: n = m ? TLR : RTI;
            RTI: n = m ? SEL_DR : RTI;
            SEL_DR: n = m ? SEL_IR : CAP_DR;
            CAP_DR: n = m ? EX1_DR : SH_DR;
            SH_DR: n = m ? EX1_DR : SH_DR;
            EX1_DR: n = m ? UPD_DR : PA_DR;
            PA_DR: n = m ? EX2_DR : PA_DR;
            EX2_DR: n = m ? UPD_DR : SH_DR;
            UPD_DR: n = m ? SEL_DR : RTI;
            SEL_IR: n = m ? TLR : CAP_IR;
            CAP_IR: n = m ? EX1_IR : SH_IR;
            SH_IR: n = m ? EX1_IR : SH_IR;
            EX1_IR: n = m ? UPD_IR : PA_IR;
            PA_IR: n = m ? EX2_IR : PA_IR;
            EX2_IR: n = m ? UPD_IR : SH_IR;
            UPD_IR: n = m ? SEL_DR : RTI;
        endcase
        return n;
    endfunction : tap_next

    // strobes for the current tap state
    function automatic bstp_tap_t tap_decode(bstp_tap_state_t s);
        bstp_tap_t t;
        t.reset = (s == TLR);
        t.capture_ir = (s == CAP_IR);
        t.shift_ir = (s == SH_IR);
        t.update_ir = (s == UPD_IR);
        t.capture_dr = (s == CAP_DR);
        t.shift_dr = (s == SH_DR);
        t.update_dr = (s == UPD_DR);
        return t;
    endfunction : tap_decode

    // instruction decode; unknown codes act as bypass
    function automatic bstp_instr_t instr_decode(logic [BSTP_IR_LEN-1:0] c);
        bstp_instr_t i;
        i = INS_BYPASS;
        if (c == BSTP_IR_EXTEST) begin
            i = INS_EXTEST;
        end else if (c == BSTP_IR_SAMPLE) begin
            i = INS_SAMPLE;
        end
        return i;
    endfunction : instr_decode

    // ****************************************************************
    // tck domain: reset, pin sampling, tap controller
    // ****************************************************************
    logic tck_rst_s1_reg;
    logic tck_rst_reg;
    logic [3*PINS-1:0] pins_s1_reg;
    logic [3*PINS-1:0] pins_s2_reg;
    bstp_tap_state_t tap_reg;
    bstp_tap_t tap;
    bstp_instr_t instr;
    logic tms_eff;
    logic tdi_eff;
    logic [BSTP_IR_LEN-1:0] ir_shift_reg;
    logic [BSTP_IR_LEN-1:0] ir_reg;
    logic bypass_reg;
    logic [BSR_LEN-1:0] bsr_reg;
    logic [BSR_LEN-1:0] hold_reg;
    logic req_tgl_reg;
    logic ack_s1_reg;
    logic ack_s2_reg;
    logic tdo_reg;
    logic tdo_oe_reg;
    logic ack_reg;
    logic ext_tck_reg;

    // undriven test inputs float to the pull-up level
    assign tms_eff = tms_drive ? tms_pin : BSTP_PULLUP_LEVEL;
    assign tdi_eff = tdi_drive ? tdi_pin : BSTP_PULLUP_LEVEL;
    assign tap = tap_decode(tap_reg);
    assign instr = instr_decode(ir_reg);

    // system reset and asynchronous pin levels brought onto tck
    always_ff @(posedge tck) begin
        tck_rst_s1_reg <= rst;
        tck_rst_reg <= tck_rst_s1_reg;
        pins_s1_reg <= {core_oe, core_out, pin_in};
        pins_s2_reg <= pins_s1_reg;
    end

    // tap state machine; tms high for five edges always ends in reset
    always_ff @(posedge tck) begin
        if (tck_rst_reg) begin
            tap_reg <= TLR;
        end else begin
            tap_reg <= tap_next(tap_reg, tms_eff);
        end
    end

    // instruction shift and update stages, three bits each
    always_ff @(posedge tck) begin
        if (tck_rst_reg || tap.reset) begin
            ir_shift_reg <= BSTP_IR_CAPTURE;
            ir_reg <= BSTP_IR_BYPASS;
            ext_tck_reg <= 1'b0;
        end else begin
            if (tap.capture_ir) begin
                ir_shift_reg <= BSTP_IR_CAPTURE;
            end else if (tap.shift_ir) begin
                ir_shift_reg <= {tdi_eff, ir_shift_reg[BSTP_IR_LEN-1:1]};
            end
            if (tap.update_ir) begin
                ir_reg <= ir_shift_reg;
                // registered flag, so the clk side never sees a decode glitch
                ext_tck_reg <= (instr_decode(ir_shift_reg) == INS_EXTEST);
            end
        end
    end

    // one-bit bypass path between tdi and tdo
    always_ff @(posedge tck) begin
        if (tck_rst_reg) begin
            bypass_reg <= BSTP_BYPASS_CAPTURE;
        end else if (instr == INS_BYPASS) begin
            if (tap.capture_dr) begin
                bypass_reg <= BSTP_BYPASS_CAPTURE;
            end else if (tap.shift_dr) begin
                bypass_reg <= tdi_eff;
            end
        end
    end

    // boundary-scan chain: capture then shift toward tdo
    always_ff @(posedge tck) begin
        if (tck_rst_reg) begin
            bsr_reg <= '0;
        end else if (instr != INS_BYPASS) begin
            if (tap.capture_dr) begin
                for (int p = 0; p < PINS; p++) begin
                    bsr_reg[3*p+BSTP_CELL_IN] <= pins_s2_reg[p];
                    if (instr == INS_SAMPLE) begin
                        bsr_reg[3*p+BSTP_CELL_OUT] <=
                            pins_s2_reg[PINS+p];
                        bsr_reg[3*p+BSTP_CELL_OE] <=
                            pins_s2_reg[2*PINS+p];
                    end
                end
            end else if (tap.shift_dr) begin
                bsr_reg <= {tdi_eff, bsr_reg[BSR_LEN-1:1]};
            end
        end
    end

    // update hands the chain to the clk side by a toggle handshake
    always_ff @(posedge tck) begin
        ack_s1_reg <= ack_reg;
        ack_s2_reg <= ack_s1_reg;
        if (tck_rst_reg) begin
            req_tgl_reg <= 1'b0;
            hold_reg <= '0;
        end else if (tap.update_dr && instr != INS_BYPASS &&
                     req_tgl_reg == ack_s2_reg) begin
            hold_reg <= bsr_reg;
            req_tgl_reg <= ~req_tgl_reg;
        end
    end

    // tdo launched on the falling edge, enabled only in shift states
    always_ff @(negedge tck) begin
        if (tck_rst_reg) begin
            tdo_reg <= 1'b0;
            tdo_oe_reg <= 1'b0;
        end else begin
            tdo_oe_reg <= tap.shift_ir | tap.shift_dr;
            if (tap.shift_ir) begin
                tdo_reg <= ir_shift_reg[0];
            end else if (instr == INS_BYPASS) begin
                tdo_reg <= bypass_reg;
            end else begin
                tdo_reg <= bsr_reg[0];
            end
        end
    end

    assign tdo = tdo_reg;
    assign tdo_oe = tdo_oe_reg;

    // ****************************************************************
    // clk domain: pattern queue and pin drive
    // ****************************************************************
    logic ext_s1_reg;
    logic ext_s2_reg;
    logic req_s1_reg;
    logic req_s2_reg;
    logic q_in_ready;
    logic q_out_valid;
    logic [BSR_LEN-1:0] q_out_data;
    logic [PINS-1:0] upd_out_reg;
    logic [PINS-1:0] upd_oe_reg;
    logic [PINS-1:0] pin_out_reg;
    logic [PINS-1:0] pin_oe_reg;

    // extest level and request toggle synchronised into clk
    always_ff @(posedge clk) begin
        ext_s1_reg <= ext_tck_reg;
        ext_s2_reg <= ext_s1_reg;
        req_s1_reg <= req_tgl_reg;
        req_s2_reg <= req_s1_reg;
    end

    // acknowledge only once the queue took the word
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_reg <= 1'b0;
        end else if (req_s2_reg != ack_reg && q_in_ready) begin
            ack_reg <= req_s2_reg;
        end
    end

    // preloaded patterns wait here until extest drains them
    bstp_fifo #(
        .WIDTH(BSR_LEN),
        .DEPTH(FIFO_DEPTH)
    ) u_queue (
        .clk(clk),
        .rst(rst),
        .in_valid(req_s2_reg != ack_reg),
        .in_ready(q_in_ready),
        .in_data(hold_reg),
        .out_valid(q_out_valid),
        .out_ready(ext_s2_reg),
        .out_data(q_out_data)
    );

    // update cells take the head word while extest holds
    always_ff @(posedge clk) begin
        if (rst) begin
            upd_out_reg <= '0;
            upd_oe_reg <= '0;
        end else if (q_out_valid && ext_s2_reg) begin
            for (int p = 0; p < PINS; p++) begin
                upd_out_reg[p] <= q_out_data[3*p+BSTP_CELL_OUT];
                upd_oe_reg[p] <= q_out_data[3*p+BSTP_CELL_OE];
            end
        end
    end

    // pin drive: update cells under extest, otherwise the core
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_out_reg <= '0;
            pin_oe_reg <= '0;
        end else if (ext_s2_reg) begin
            pin_out_reg <= upd_out_reg;
            pin_oe_reg <= upd_oe_reg;
        end else begin
            pin_out_reg <= core_out;
            pin_oe_reg <= core_oe;
        end
    end

    assign pin_out = pin_out_reg;
    assign pin_oe = pin_oe_reg;

endmodule : bstp_top

`default_nettype wire

// >>> verification/bstp_ctl.sv
// board test controller model that drives the scan link
`timescale 1ns/1ps
`default_nettype none

module bstp_ctl (
    output logic tck,
    output logic tms_pin,
    output logic tms_drive,
    output logic tdi_pin,
    output logic tdi_drive,
    input wire logic tdo
);
    // ********
    // link idle: tck still, lines released
    // ********
    initial begin
        tck = 1'h0;
        tms_pin = 1'h0;
        tms_drive = 1'h0;
        tdi_pin = 1'h0;
        tdi_drive = 1'h0;
    end

    // one tck period; a high tms is left to the pull-up when dd is low
    task automatic step(input logic m, input logic d, input logic dd,
                        output logic o);
        tms_drive = dd | ~m;
        tms_pin = tms_drive ? m : 1'h0;
        tdi_drive = dd;
        tdi_pin = dd ? d : ~d;
        #3;
        o = tdo;
        tck = 1'h1;
        #3;
        tck = 1'h0;
    endtask : step

    // release the lines; the released data line shows a stale inverse
    task automatic idle();
        tms_drive = 1'h0;
        tdi_drive = 1'h0;
        tdi_pin = ~tdi_pin;
        #3;
    endtask : idle

    // five tck with tms high, then run-test/idle
    task automatic tap_reset(input logic drv);
        logic o;
        repeat (5) step(1'h1, 1'h0, drv, o);
        step(1'h0, 1'h0, 1'h1, o);
        idle();
    endtask : tap_reset

    // shift n bits lsb first from run-test/idle and back
    task automatic scan(input logic ir, input int n, input logic [1023:0] din,
                        input logic drv, output logic [1023:0] dout);
        logic o;
        dout = '0;
        step(1'h1, 1'h0, 1'h1, o);
        if (ir) step(1'h1, 1'h0, 1'h1, o);
        step(1'h0, 1'h0, 1'h1, o);
        step(1'h0, 1'h0, 1'h1, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], drv, o);
            dout[i] = o;
        end
        step(1'h1, 1'h0, 1'h1, o);
        step(1'h0, 1'h0, 1'h1, o);
        idle();
    endtask : scan
endmodule : bstp_ctl

`default_nettype wire

// >>> verification/bstp_top_asserts.sv
// concurrent checks on the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none

module bstp_top_asserts
    import bstp_pkg::*;
#(
    parameter int BSR_LEN = BSTP_BSR_LEN_DEFAULT,
    localparam int PINS = BSR_LEN / BSTP_CELLS_PER_PIN
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms_pin,
    input wire logic tms_drive,
    input wire logic tdi_pin,
    input wire logic tdi_drive,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic [PINS-1:0] pin_in,
    input wire logic [PINS-1:0] core_out,
    input wire logic [PINS-1:0] core_oe,
    input wire logic [PINS-1:0] pin_out,
    input wire logic [PINS-1:0] pin_oe
);
    // ********
    // reference tap walk
    // ********
    logic tms_e, tdi_e, byp, ext1_reg, ext2_reg;
    logic [BSTP_IR_LEN-1:0] irs_reg, ir_reg;
    logic [2:0] cnt_reg;
    logic [BSR_LEN-1:0] dly_reg;
    int n_reg;
    bstp_tap_state_t st_reg, st_next;

    // effective link inputs and bypass decode
    assign tms_e = tms_drive ? tms_pin : 1'h1;
    assign tdi_e = tdi_drive ? tdi_pin : 1'h1;
    assign byp = ir_reg != BSTP_IR_EXTEST && ir_reg != BSTP_IR_SAMPLE;

    // tap next state
    always_comb begin
        case (st_reg)
            TLR: st_next = tms_e ? TLR : RTI;
            RTI: st_next = tms_e ? SEL_DR : RTI;
            SEL_DR: st_next = tms_e ? SEL_IR : CAP_DR;
            CAP_DR: st_next = tms_e ? EX1_DR : SH_DR;
            SH_DR: st_next = tms_e ? EX1_DR : SH_DR;
            EX1_DR: st_next = tms_e ? UPD_DR : PA_DR;
            PA_DR: st_next = tms_e ? EX2_DR : PA_DR;
            EX2_DR: st_next = tms_e ? UPD_DR : SH_DR;
            UPD_DR: st_next = tms_e ? SEL_DR : RTI;
            SEL_IR: st_next = tms_e ? TLR : CAP_IR;
            CAP_IR: st_next = tms_e ? EX1_IR : SH_IR;
            SH_IR: st_next = tms_e ? EX1_IR : SH_IR;
            EX1_IR: st_next = tms_e ? UPD_IR : PA_IR;
            PA_IR: st_next = tms_e ? EX2_IR : PA_IR;
            EX2_IR: st_next = tms_e ? UPD_IR : SH_IR;
            default: st_next = tms_e ? SEL_DR : RTI;
        endcase
    end

    // tap state
    always_ff @(posedge tck) begin
        st_reg <= rst ? TLR : st_next;
    end

    // instruction shift and hold
    always_ff @(posedge tck) begin
        if (st_reg == CAP_IR) irs_reg <= BSTP_IR_CAPTURE;
        else if (st_reg == SH_IR) irs_reg <= {tdi_e, irs_reg[2:1]};
        if (rst || st_reg == TLR) ir_reg <= BSTP_IR_BYPASS;
        else if (st_reg == UPD_IR) ir_reg <= irs_reg;
    end

    // data shift count and delayed tdi
    always_ff @(posedge tck) begin
        if (st_reg == CAP_DR) n_reg <= 0;
        else if (st_reg == SH_DR) n_reg <= n_reg + 1;
        if (st_reg == SH_DR) dly_reg <= {tdi_e, dly_reg[BSR_LEN-1:1]};
    end

    // extest level seen in the system clock and its age
    always_ff @(posedge clk) begin
        ext1_reg <= ir_reg == BSTP_IR_EXTEST;
        ext2_reg <= ext1_reg;
        if (rst || ext2_reg != ext1_reg) cnt_reg <= 3'h0;
        else if (cnt_reg != 3'h7) cnt_reg <= cnt_reg + 3'h1;
    end

    property p_tdo_oe;
        @(posedge tck) disable iff (rst)
        tdo_oe == (st_reg == SH_IR || st_reg == SH_DR);
    endproperty
    a_tdo_oe: assert property (p_tdo_oe)
        else $error("tdo enable outside shift");
    property p_byp_cap;
        @(posedge tck) disable iff (rst)
        st_reg == SH_DR && $past(st_reg) == CAP_DR && byp
        |-> tdo == BSTP_BYPASS_CAPTURE;
    endproperty
    a_byp_cap: assert property (p_byp_cap)
        else $error("bypass capture wrong");
    property p_byp_delay;
        @(posedge tck) disable iff (rst)
        st_reg == SH_DR && $past(st_reg) == SH_DR && byp
        |-> tdo == $past(tdi_e);
    endproperty
    a_byp_delay: assert property (p_byp_delay)
        else $error("bypass delay wrong");
    property p_ir_cap;
        @(posedge tck) disable iff (rst)
        st_reg == SH_IR && $past(st_reg) == CAP_IR
        |-> tdo ##1 !tdo ##1 !tdo;
    endproperty
    a_ir_cap: assert property (p_ir_cap)
        else $error("instruction capture wrong");
    property p_cell_cap;
        @(posedge tck) disable iff (rst)
        st_reg == SH_DR && $past(st_reg) == CAP_DR && !byp
        |-> tdo == pin_in[0];
    endproperty
    a_cell_cap: assert property (p_cell_cap)
        else $error("input cell capture wrong");
    property p_dr_len;
        @(posedge tck) disable iff (rst)
        st_reg == SH_DR && !byp && n_reg == BSR_LEN |-> tdo == dly_reg[0];
    endproperty
    a_dr_len: assert property (p_dr_len)
        else $error("scan length wrong");
    property p_tms_reset;
        @(posedge tck) disable iff (rst)
        tms_e [*5] |=> !tdo_oe;
    endproperty
    a_tms_reset: assert property (p_tms_reset)
        else $error("tms reset failed");
    property p_core_follow;
        @(posedge clk) disable iff (rst)
        cnt_reg == 3'h7 && !ext2_reg
        |-> pin_out == $past(core_out) && pin_oe == $past(core_oe);
    endproperty
    a_core_follow: assert property (p_core_follow)
        else $error("pins not from core");
endmodule : bstp_top_asserts

bind bstp_top bstp_top_asserts #(.BSR_LEN(BSR_LEN)) u_chk (
    .clk(clk), .rst(rst), .tck(tck), .tms_pin(tms_pin),
    .tms_drive(tms_drive), .tdi_pin(tdi_pin), .tdi_drive(tdi_drive),
    .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .core_out(core_out),
    .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe)
);

`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none

module tb;
    import bstp_pkg::*;
    localparam int BSR = BSTP_BSR_LEN_DEFAULT;
    localparam int PINS = BSR / BSTP_CELLS_PER_PIN;
    logic clk, rst, tck, tms_pin, tms_drive, tdi_pin, tdi_drive, tdo, tdo_oe;
    logic [PINS-1:0] pin_in, core_out, core_oe, pin_out, pin_oe;
    logic [1023:0] sout;
    int errors, total_checks;

    bstp_top #(.BSR_LEN(BSR), .FIFO_DEPTH(BSTP_FIFO_DEPTH)) dut (
        .clk(clk), .rst(rst), .tck(tck), .tms_pin(tms_pin),
        .tms_drive(tms_drive), .tdi_pin(tdi_pin), .tdi_drive(tdi_drive),
        .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .core_out(core_out),
        .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe)
    );
    bstp_ctl ctl (
        .tck(tck), .tms_pin(tms_pin), .tms_drive(tms_drive),
        .tdi_pin(tdi_pin), .tdi_drive(tdi_drive), .tdo(tdo)
    );

    // ********
    // helpers
    // ********
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    function automatic logic [PINS-1:0] pat(input int k, input int m);
        for (int p = 0; p < PINS; p++)
            pat[p] = (p + k) % m == 0;
    endfunction : pat

    // scan word from per-pin input, output and enable cells
    function automatic logic [1023:0] word(input logic [PINS-1:0] i_v,
                                          o_v, e_v);
        word = '0;
        for (int p = 0; p < PINS; p++) begin
            word[3*p+BSTP_CELL_IN] = i_v[p];
            word[3*p+BSTP_CELL_OUT] = o_v[p];
            word[3*p+BSTP_CELL_OE] = e_v[p];
        end
    endfunction : word

    task automatic chk_p(input string n, input logic [PINS-1:0] e, g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask : chk_p

    task automatic chk_s(input string n, input logic [1023:0] e, g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask : chk_s

    task automatic load_ir(input logic [BSTP_IR_LEN-1:0] c);
        ctl.scan(1'h1, BSTP_IR_LEN, {1021'h0, c}, 1'h1, sout);
    endtask : load_ir

    // ********
    // scenarios
    // ********
    task automatic t_bypass();
        // an unused code must act as bypass for the scans below
        load_ir(3'h3);
        chk_s("odd ir capture", 1024'h1, sout);
        ctl.scan(1'h0, 8, 1024'hB4, 1'h1, sout);
        chk_s("bypass", 1024'h68, sout);
        ctl.scan(1'h0, 8, 1024'h0, 1'h0, sout);
        chk_s("pullup", 1024'hFE, sout);
        load_ir(BSTP_IR_BYPASS);
        chk_s("ir capture", 1024'h1, sout);
        @(negedge clk);
        chk_p("core out", core_out, pin_out);
    endtask : t_bypass

    task automatic t_sample();
        load_ir(BSTP_IR_SAMPLE);
        ctl.scan(1'h0, BSR, word(pat(0, 5), pat(1, 5), pat(2, 5)), 1'h1, sout);
        chk_s("sample", word(pin_in, core_out, core_oe), sout);
        repeat (10) @(negedge clk);
        chk_p("held out", core_out, pin_out);
        chk_p("held oe", core_oe, pin_oe);
    endtask : t_sample

    task automatic t_extest();
        load_ir(BSTP_IR_EXTEST);
        @(negedge clk);
        core_out = ~core_out;
        repeat (10) @(negedge clk);
        chk_p("preload out", pat(1, 5), pin_out);
        chk_p("preload oe", pat(2, 5), pin_oe);
        ctl.scan(1'h0, BSR + 4, word(pat(0, 7), pat(1, 7), pat(2, 7)) << 4,
                 1'h1, sout);
        chk_s("extest", word(pin_in, pat(1, 5), pat(2, 5)), sout);
        repeat (10) @(negedge clk);
        chk_p("update out", pat(1, 7), pin_out);
    endtask : t_extest

    // words queue under sample and drain in order once extest starts
    task automatic t_queue();
        logic [PINS-1:0] last;
        logic [PINS-1:0] q[$];
        load_ir(BSTP_IR_SAMPLE);
        for (int w = 0; w < 11; w++)
            ctl.scan(1'h0, BSR, word('0, pat(w, 13), '1), 1'h1, sout);
        last = pin_out;
        fork
            load_ir(BSTP_IR_EXTEST);
            repeat (40) @(negedge clk) begin
                if (pin_out !== last && pin_out !== pat(1, 7))
                    q.push_back(pin_out);
                last = pin_out;
            end
        join
        for (int i = 0; i < 10; i++)
            chk_p("queue order", pat(i, 13), q[i]);
        chk_p("queue drop", PINS'(4'hA), PINS'(q.size()));
    endtask : t_queue

    task automatic t_tms();
        ctl.tap_reset(1'h0);
        repeat (10) @(negedge clk);
        chk_p("reset out", core_out, pin_out);
        chk_p("reset oe", core_oe, pin_oe);
    endtask : t_tms

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    // main sequence
    initial begin
        errors = 0;
        total_checks = 0;
        rst = 1'h1;
        pin_in = pat(2, 3);
        core_out = pat(0, 3);
        core_oe = pat(1, 3);
        @(negedge clk);
        ctl.tap_reset(1'h1);
        repeat (4) @(negedge clk);
        rst = 1'h0;
        ctl.tap_reset(1'h1);
        t_bypass();
        t_sample();
        t_extest();
        t_queue();
        t_tms();
        stop_test();
    end

    // watchdog
    initial begin
        #200000;
        errors = errors + 1;
        stop_test();
    end
endmodule : tb

`default_nettype wire
